// *** design/pin_sync.sv ***
// Three-stage pin synchroniser with agreement filter and edge pulses.
`timescale 1ns/100ps
module pin_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic aclk, // System clock.
    input wire logic aresetn, // Synchronous reset, active low.
    input wire logic [W-1:0] din, // Asynchronous pin level.
    output logic [W-1:0] level, // Filtered level.
    output logic [W-1:0] rise, // One-cycle pulse on a rising change.
    output logic [W-1:0] fall // One-cycle pulse on a falling change.
);
    logic [W-1:0] s1_r, s2_r, s3_r, lvl_nxt;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_r <= INIT;
            s2_r <= INIT;
            s3_r <= INIT;
        end else begin
            s1_r <= din;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // A change only counts once the last two stages agree.
    always_comb begin
        lvl_nxt = (s2_r & ~(s2_r ^ s3_r)) | (level & (s2_r ^ s3_r));
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            level <= INIT;
            rise <= '0;
            fall <= '0;
        end else begin
            level <= lvl_nxt;
            rise <= lvl_nxt & ~level;
            fall <= ~lvl_nxt & level;
        end
    end
endmodule : pin_sync

// *** design/sleep_and_watchdog_control.sv ***
// Sleep controller and watchdog with an AXI4-Lite register slave.
`timescale 1ns/100ps
`include "sleep_wdt_map.svh"
module sleep_and_watchdog_control #(
    parameter int CNT_W = 24,
    parameter int OST_COUNT = `OST_CYCLES
) (
    input wire logic aclk, // System clock, 25 MHz.
    input wire logic aresetn, // Synchronous reset, active low.
    input wire logic [3:0] awaddr, // Write address.
    input wire logic awvalid, // Write address valid.
    output logic awready, // Write address ready.
    input wire logic [31:0] wdata, // Write data.
    input wire logic [3:0] wstrb, // Write byte strobes.
    input wire logic wvalid, // Write data valid.
    output logic wready, // Write data ready.
    output logic [1:0] bresp, // Write response.
    output logic bvalid, // Write response valid.
    input wire logic bready, // Write response ready.
    input wire logic [3:0] araddr, // Read address.
    input wire logic arvalid, // Read address valid.
    output logic arready, // Read address ready.
    output logic [31:0] rdata, // Read data.
    output logic [1:0] rresp, // Read response.
    output logic rvalid, // Read data valid.
    input wire logic rready, // Read data ready.
    input wire logic sleep_instr, // Core executes sleep, pulse.
    input wire logic watchdog_clear_instruction, // Core clears dog, pulse.
    input wire logic int_wake_pend, // Some enabled interrupt is pending.
    input wire logic global_interrupt_enable, // Core global enable.
    input wire logic osc_fail, // Oscillator fail event, pulse.
    input wire logic ost_running, // Start-up timer is running.
    input wire logic master_clear_input_n, // Master clear pin, low.
    input wire logic brownout_reset, // Brown-out detected.
    input wire logic power_on_reset, // Power-on detected.
    input wire logic low_freq_internal_oscillator, // 31 kHz clock pin.
    output logic core_clk_en, // Core clock enable.
    output logic io_hold, // Freeze port drivers.
    output logic prefetch_next, // Fetch next instruction, pulse.
    output logic resume_inline, // Continue after sleep, pulse.
    output logic isr_call, // Vector to service routine, pulse.
    output logic device_reset, // Restart the device.
    output logic sleeping, // Device is in power-down.
    output logic power_down_flag, // Power-down status flag.
    output logic time_out_flag // Time-out status flag.
);
    sleep_wdt_pkg::pstate_t state_r, state_nxt;
    sleep_wdt_pkg::cfg_t cfg_r;
    sleep_wdt_pkg::wdt_ctl_t ctl_r;

    logic master_clear_input_lvl;
    logic lf_tick;
    logic wdt_timeout;
    logic wdt_clear;
    logic wdt_on;
    logic rst_src;
    logic asleep;
    logic sleep_take;
    logic sleep_go;
    logic wake;
    logic wake_wdt;
    logic wdt_bite;
    logic ost_done;
    logic woke_int_r;
    logic [$clog2(OST_COUNT+1)-1:0] ost_cnt_r;

    logic aw_hold_r, w_hold_r;
    logic [3:0] awaddr_r;
    logic [7:0] wbyte_r;
    logic wlane_r;
    logic do_write;
    logic [31:0] rd_data;
    logic rd_ok;
    logic wr_ok;

    pin_sync #(
        .W(1),
        .INIT(1'b1)
    ) u_master_clear_input_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .din(master_clear_input_n),
        .level(master_clear_input_lvl),
        .rise(),
        .fall()
    );

    pin_sync #(
        .W(1),
        .INIT(1'b0)
    ) u_lf_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .din(low_freq_internal_oscillator),
        .level(),
        .rise(lf_tick),
        .fall()
    );

    wdt_prescaler #(
        .CNT_W(CNT_W)
    ) u_wdt (
        .aclk(aclk),
        .aresetn(aresetn),
        .clear(wdt_clear),
        .tick(lf_tick),
        .period_sel(ctl_r.period),
        .timeout(wdt_timeout)
    );

    // Reset sources pass straight through whether asleep or not.
    always_comb begin
        rst_src = power_on_reset
            | (brownout_reset & cfg_r.bor_en)
            | (~master_clear_input_lvl & cfg_r.master_clear_input_en);
    end

    always_comb begin
        asleep = (state_r == sleep_wdt_pkg::ST_SLEEP);
        case (cfg_r.mode)
            `WDT_MODE_ON: wdt_on = 1'b1;
            `WDT_MODE_AWAKE: wdt_on = !asleep;
            `WDT_MODE_SOFT: wdt_on = ctl_r.swen;
            default: wdt_on = 1'b0;
        endcase
    end

    always_comb begin
        sleep_take = sleep_instr && !rst_src
            && (state_r == sleep_wdt_pkg::ST_AWAKE);
        sleep_go = sleep_take && !int_wake_pend;
        wake_wdt = asleep && wdt_timeout;
        wake = asleep && !rst_src
            && (int_wake_pend || wdt_timeout);
        wdt_bite = wdt_timeout && !asleep;
        ost_done = (ost_cnt_r == OST_COUNT - 1);
    end

    // A no-op sleep must not clear the counter.
    always_comb begin
        wdt_clear = rst_src || device_reset
            || watchdog_clear_instruction
            || sleep_go
            || wake
            || osc_fail
            || !wdt_on
            || ost_running
            || (state_r == sleep_wdt_pkg::ST_OST);
    end

    always_comb begin
        state_nxt = state_r;
        if (rst_src || wdt_bite) begin
            state_nxt = sleep_wdt_pkg::ST_AWAKE;
        end else begin
            case (state_r)
                sleep_wdt_pkg::ST_AWAKE: begin
                    if (sleep_go) begin
                        state_nxt = sleep_wdt_pkg::ST_SLEEP;
                    end
                end
                sleep_wdt_pkg::ST_SLEEP: begin
                    if (wake) begin
                        state_nxt = cfg_r.xtal ? sleep_wdt_pkg::ST_OST
                            : sleep_wdt_pkg::ST_RESUME;
                    end
                end
                sleep_wdt_pkg::ST_OST: begin
                    if (ost_done) begin
                        state_nxt = sleep_wdt_pkg::ST_RESUME;
                    end
                end
                sleep_wdt_pkg::ST_RESUME: begin
                    state_nxt = sleep_wdt_pkg::ST_AWAKE;
                end
                default: begin
                    state_nxt = sleep_wdt_pkg::ST_AWAKE;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= sleep_wdt_pkg::ST_AWAKE;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || state_r != sleep_wdt_pkg::ST_OST) begin
            ost_cnt_r <= '0;
        end else if (!ost_done) begin
            ost_cnt_r <= ost_cnt_r + 1'b1;
        end
    end

    // Remember the wake cause so a wake with no interrupt pending never vectors.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            woke_int_r <= 1'b0;
        end else if (wake) begin
            woke_int_r <= int_wake_pend;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            core_clk_en <= 1'b1;
            io_hold <= 1'b0;
            sleeping <= 1'b0;
        end else begin
            core_clk_en <= (state_nxt == sleep_wdt_pkg::ST_AWAKE)
                || (state_nxt == sleep_wdt_pkg::ST_RESUME);
            io_hold <= (state_nxt == sleep_wdt_pkg::ST_SLEEP)
                || (state_nxt == sleep_wdt_pkg::ST_OST);
            sleeping <= (state_nxt == sleep_wdt_pkg::ST_SLEEP);
        end
    end

    // The core runs the prefetched word first, then takes the vector.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prefetch_next <= 1'b0;
            resume_inline <= 1'b0;
            isr_call <= 1'b0;
        end else begin
            prefetch_next <= sleep_take;
            resume_inline <= (state_r == sleep_wdt_pkg::ST_RESUME)
                && !rst_src;
            isr_call <= (state_r == sleep_wdt_pkg::ST_RESUME)
                && !rst_src && woke_int_r
                && global_interrupt_enable;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            device_reset <= 1'b0;
        end else begin
            device_reset <= rst_src || wdt_bite;
        end
    end

    // Hardware alone moves the flags; software can only read them.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            time_out_flag <= 1'b1;
            power_down_flag <= 1'b1;
        end else if (power_on_reset
            || (brownout_reset && cfg_r.bor_en)) begin
            time_out_flag <= 1'b1;
            power_down_flag <= 1'b1;
        end else if (wdt_bite) begin
            time_out_flag <= 1'b0;
            power_down_flag <= 1'b1;
        end else if (wake_wdt && !rst_src) begin
            time_out_flag <= 1'b0;
            power_down_flag <= 1'b0;
        end else if (sleep_go) begin
            time_out_flag <= 1'b1;
            power_down_flag <= 1'b0;
        end else if (watchdog_clear_instruction
            && state_r == sleep_wdt_pkg::ST_AWAKE) begin
            time_out_flag <= 1'b1;
            power_down_flag <= 1'b1;
        end
    end

    // Write channel: address and data are taken in either order.
    always_comb begin
        do_write = aw_hold_r && w_hold_r && !bvalid;
        wr_ok = (awaddr_r == `REG_CORE_STATUS)
            || (awaddr_r == `REG_WDT_CTRL)
            || (awaddr_r == `REG_WDT_CONFIG)
            || (awaddr_r == `REG_BLOCK_STATE);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b0;
            wready <= 1'b0;
        end else begin
            awready <= awvalid && !awready && !aw_hold_r && !bvalid;
            wready <= wvalid && !wready && !w_hold_r && !bvalid;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_r <= 1'b0;
            awaddr_r <= 4'h0;
        end else if (awvalid && awready) begin
            aw_hold_r <= 1'b1;
            awaddr_r <= {awaddr[3:2], 2'b00};
        end else if (do_write) begin
            aw_hold_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_hold_r <= 1'b0;
            wbyte_r <= 8'h00;
            wlane_r <= 1'b0;
        end else if (wvalid && wready) begin
            w_hold_r <= 1'b1;
            wbyte_r <= wdata[7:0];
            wlane_r <= wstrb[0];
        end else if (do_write) begin
            w_hold_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp <= `AXI_OKAY;
        end else if (do_write) begin
            bvalid <= 1'b1;
            bresp <= wr_ok ? `AXI_OKAY : `AXI_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // Any device reset restores the period code, even over a write.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctl_r <= '{period: `PS_RESET, swen: 1'b0};
        end else if (rst_src || wdt_bite) begin
            ctl_r.period <= `PS_RESET;
        end else if (do_write && wlane_r
            && awaddr_r == `REG_WDT_CTRL) begin
            ctl_r.period <= wbyte_r[`CTL_PS_MSB:`CTL_PS_LSB];
            ctl_r.swen <= wbyte_r[`CTL_SWEN_BIT];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_r <= sleep_wdt_pkg::cfg_t'(`CFG_RESET);
        end else if (do_write && wlane_r
            && awaddr_r == `REG_WDT_CONFIG) begin
            cfg_r.mode <= wbyte_r[`CFG_MODE_MSB:`CFG_MODE_LSB];
            cfg_r.xtal <= wbyte_r[`CFG_XTAL_BIT];
            cfg_r.master_clear_input_en <= wbyte_r[`CFG_MASTER_CLEAR_INPUT_EN_BIT];
            cfg_r.bor_en <= wbyte_r[`CFG_BOR_EN_BIT];
        end
    end

    // Read decode; unused bits read as zero.
    always_comb begin
        rd_data = 32'h0000_0000;
        rd_ok = 1'b1;
        case ({araddr[3:2], 2'b00})
            `REG_CORE_STATUS: begin
                rd_data[`STS_TO_BIT] = time_out_flag;
                rd_data[`STS_PD_BIT] = power_down_flag;
            end
            `REG_WDT_CTRL: begin
                rd_data[`CTL_PS_MSB:`CTL_PS_LSB] = ctl_r.period;
                rd_data[`CTL_SWEN_BIT] = ctl_r.swen;
            end
            `REG_WDT_CONFIG: begin
                rd_data[`CFG_MODE_MSB:`CFG_MODE_LSB] = cfg_r.mode;
                rd_data[`CFG_XTAL_BIT] = cfg_r.xtal;
                rd_data[`CFG_MASTER_CLEAR_INPUT_EN_BIT] = cfg_r.master_clear_input_en;
                rd_data[`CFG_BOR_EN_BIT] = cfg_r.bor_en;
            end
            `REG_BLOCK_STATE: begin
                rd_data[1:0] = state_r;
                rd_data[2] = wdt_on;
            end
            default: begin
                rd_ok = 1'b0;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
        end else begin
            arready <= arvalid && !arready && !rvalid;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= `AXI_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata <= rd_data;
            rresp <= rd_ok ? `AXI_OKAY : `AXI_SLVERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end
endmodule : sleep_and_watchdog_control

// *** design/sleep_wdt_map.svh ***
// Offsets, field positions, reset values and timing counts for the block.
// Contract
// - Power-down is entered only when the core executes the sleep instruction.
// - Sleep entry clears the power-down flag and sets the time-out flag.
// - Sleep entry clears the watchdog; it keeps counting if enabled in sleep.
// - Sleep gates the core clock; the slow oscillators keep running.
// - In sleep every port holds the level it drove before sleep.
// - Sleep changes no reset source except the watchdog.
// - Wake on master clear, brown-out, power-on, watchdog or enabled interrupts.
// - The instruction after sleep is prefetched while sleep executes.
// - An interrupt wakes only if enabled, whatever the global enable holds.
// - Global enable off resumes in line; on runs next instruction then ISR.
// - Every wake-up from sleep clears the watchdog counter.
// - A pending enabled interrupt turns sleep into a no-op, nothing changes.
// - Interrupt during sleep instruction: sleep completes, wakes at once.
// - Crystal modes wait 1024 oscillator periods on wake; others do not.
// - Watchdog expiry without a clear instruction resets the device.
// - The watchdog counts ticks of the independent 31 kHz oscillator.
// - Mode 11 keeps the watchdog on always, soft enable ignored.
// - Mode 10 runs the watchdog awake, stops it in sleep.
// - Mode 01 runs the watchdog exactly while the soft enable is one.
// - Period select spans 1 ms to 256 s; any reset restores 2 s.
// - Counter cleared on reset, clear, sleep edges, osc fail, off, start-up.
// - Watchdog expiry in sleep wakes the device instead of resetting it.
// - Code 0 is 1:32, doubling to code 10010; higher codes give 1:32.
`ifndef SLEEP_WDT_MAP_SVH
`define SLEEP_WDT_MAP_SVH
`define REG_CORE_STATUS 4'h0
`define REG_WDT_CTRL 4'h4
`define REG_WDT_CONFIG 4'h8
`define REG_BLOCK_STATE 4'hC
`define STS_TO_BIT 4
`define STS_PD_BIT 3
`define CTL_SWEN_BIT 0
`define CTL_PS_LSB 1
`define CTL_PS_MSB 5
`define CFG_MODE_LSB 0
`define CFG_MODE_MSB 1
`define CFG_XTAL_BIT 2
`define CFG_MASTER_CLEAR_INPUT_EN_BIT 3
`define CFG_BOR_EN_BIT 4
`define WDT_MODE_OFF 2'h0
`define WDT_MODE_SOFT 2'h1
`define WDT_MODE_AWAKE 2'h2
`define WDT_MODE_ON 2'h3
`define PS_RESET 5'h0B
`define PS_MAX 5'h12
`define CFG_RESET 5'h1B
`define LF_BASE_TICKS 24'h000020
`define OST_PERIODS 1024
`define OST_TOSC_PER_CYCLE 1
`define OST_CYCLES (`OST_PERIODS / `OST_TOSC_PER_CYCLE)
`define AXI_OKAY 2'h0
`define AXI_SLVERR 2'h2
`endif

// *** design/sleep_wdt_pkg.sv ***
// Types and shared decode for the sleep and watchdog controller.
`include "sleep_wdt_map.svh"
package sleep_wdt_pkg;
    typedef enum logic [1:0] {
        ST_AWAKE,
        ST_SLEEP,
        ST_OST,
        ST_RESUME
    } pstate_t;

    typedef struct packed {
        logic bor_en;
        logic master_clear_input_en;
        logic xtal;
        logic [1:0] mode;
    } cfg_t;

    typedef struct packed {
        logic [4:0] period;
        logic swen;
    } wdt_ctl_t;

    // Reserved codes fall back to the shortest interval.
    function automatic logic [23:0] period_limit(input logic [4:0] ps);
        if (ps > `PS_MAX) begin
            return `LF_BASE_TICKS;
        end
        return `LF_BASE_TICKS << ps;
    endfunction : period_limit
endpackage : sleep_wdt_pkg

// *** design/wdt_prescaler.sv ***
// Watchdog tick counter with selectable time-out.
`timescale 1ns/100ps
module wdt_prescaler #(
    parameter int CNT_W = 24
) (
    input wire logic aclk, // System clock.
    input wire logic aresetn, // Synchronous reset, active low.
    input wire logic clear, // Hold the counter at zero.
    input wire logic tick, // Slow oscillator tick enable.
    input wire logic [4:0] period_sel, // Time-out code.
    output logic timeout // One-cycle pulse at expiry.
);
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] last;
    logic at_end;

    always_comb begin
        last = CNT_W'(sleep_wdt_pkg::period_limit(period_sel)) - CNT_W'(1);
        at_end = (cnt_r == last);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || clear) begin
            cnt_r <= '0;
        end else if (tick) begin
            cnt_r <= at_end ? '0 : cnt_r + CNT_W'(1);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timeout <= 1'b0;
        end else begin
            timeout <= !clear && tick && at_end;
        end
    end
endmodule : wdt_prescaler

// *** tb/core_model.sv ***
// Behavioural core that issues sleep, clear and interrupt requests.
`timescale 1ns/100ps
module core_model (
    input wire logic aclk, // Clock.
    output logic sleep_instr, // Sleep pulse.
    output logic watchdog_clear_instruction, // Clear pulse.
    output logic osc_fail, // Oscillator fail pulse.
    output logic int_wake_pend, // Enabled interrupt pending.
    output logic global_interrupt_enable // Global enable.
);
    logic [2:0] ins = 3'h0;
    assign {osc_fail, watchdog_clear_instruction, sleep_instr} = ins;
    initial begin
        {int_wake_pend, global_interrupt_enable} = 2'h0;
    end
    task automatic op(input int k);
        ins[k] <= 1'b1;
        @(posedge aclk);
        ins[k] <= 1'b0;
    endtask : op
    task automatic irq(input logic p, input logic g);
        int_wake_pend <= p;
        global_interrupt_enable <= g;
    endtask : irq
endmodule : core_model

// *** tb/sleep_wdt_checker.sv ***
// Port assertions for the sleep and watchdog controller.
`timescale 1ns/100ps
module sleep_wdt_checker (
    input wire logic aclk, // Clock.
    input wire logic aresetn, // Reset, low.
    input wire logic sleep_instr, // Sleep pulse.
    input wire logic int_wake_pend, // Wake request.
    input wire logic global_interrupt_enable, // Global enable.
    input wire logic core_clk_en, // Core clock.
    input wire logic io_hold, // Port freeze.
    input wire logic prefetch_next, // Prefetch.
    input wire logic resume_inline, // Resume.
    input wire logic isr_call, // Vector.
    input wire logic device_reset, // Restart.
    input wire logic sleeping, // Asleep.
    input wire logic power_down_flag, // Flag.
    input wire logic time_out_flag // Flag.
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence enter_s;
        !sleeping ##1 sleeping;
    endsequence
    sequence wake_s;
        ##[1:40] resume_inline;
    endsequence
    AST_ENTER_CAUSE: assert property (enter_s |-> $past(sleep_instr))
        else $error("sleep entered without request");
    AST_ENTER_FLAGS: assert property (
        enter_s |-> !power_down_flag && time_out_flag)
        else $error("flags wrong on sleep entry");
    AST_GATE: assert property (sleeping |-> !core_clk_en && io_hold)
        else $error("clock or ports not frozen in sleep");
    AST_PREFETCH: assert property (prefetch_next |-> $past(sleep_instr))
        else $error("prefetch without sleep");
    AST_NOOP: assert property (
        sleep_instr && int_wake_pend && !sleeping && core_clk_en
        |=> prefetch_next && !sleeping && $stable(power_down_flag)
        && $stable(time_out_flag))
        else $error("pending sleep was not a no-op");
    AST_INT_WAKE: assert property (sleeping && int_wake_pend |-> wake_s)
        else $error("interrupt did not wake");
    AST_ISR_GIE: assert property (
        isr_call |-> resume_inline && global_interrupt_enable)
        else $error("vector without global enable");
    AST_SLEEP_WDT: assert property (
        $fell(time_out_flag) && $past(sleeping)
        |-> !device_reset && !power_down_flag)
        else $error("sleep expiry handled wrongly");
endmodule : sleep_wdt_checker

bind sleep_and_watchdog_control sleep_wdt_checker chk (
    .aclk, .aresetn, .sleep_instr, .int_wake_pend, .global_interrupt_enable,
    .core_clk_en, .io_hold, .prefetch_next, .resume_inline, .isr_call,
    .device_reset, .sleeping, .power_down_flag, .time_out_flag
);

// *** tb/tb_sleep_and_watchdog_control.sv ***
// Self-checking bench for the sleep and watchdog controller.
`timescale 1ns/100ps
module tb_sleep_and_watchdog_control;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid;
    logic [3:0] awaddr, araddr, wstrb;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp;
    logic sleep_instr, watchdog_clear_instruction, osc_fail, int_wake_pend;
    logic global_interrupt_enable, ost_running, master_clear_input_n;
    logic brownout_reset, power_on_reset, core_clk_en, io_hold, prefetch_next;
    logic resume_inline, isr_call, device_reset, sleeping;
    logic power_down_flag, time_out_flag, low_freq_internal_oscillator;
    logic [2:0] lfc;
    int error_cnt = 0;
    int compares = 0;
    int n;
    int tq[3] = '{5, 10, 5};
    logic [31:0] ctl[3] = '{32'h0, 32'h2, 32'h26};

    sleep_and_watchdog_control #(.OST_COUNT(8)) uut (
        .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
        .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
        .rresp, .rvalid, .rready, .sleep_instr, .watchdog_clear_instruction,
        .int_wake_pend, .global_interrupt_enable, .osc_fail, .ost_running,
        .master_clear_input_n, .brownout_reset, .power_on_reset,
        .low_freq_internal_oscillator, .core_clk_en, .io_hold, .prefetch_next,
        .resume_inline, .isr_call, .device_reset, .sleeping, .power_down_flag,
        .time_out_flag
    );
    core_model core (.aclk, .sleep_instr, .watchdog_clear_instruction,
        .osc_fail, .int_wake_pend, .global_interrupt_enable);

    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        lfc <= lfc + 3'h1;
    end
    assign low_freq_internal_oscillator = lfc[2];

    task automatic close_out(input bit hang);
        if (hang) error_cnt++;
        if (error_cnt == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : close_out
    task automatic check(input string nm, input logic [31:0] s,
                         input logic [31:0] e);
        compares++;
        if (s !== e) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask : check
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        int k;
        k = 0;
        {awaddr, wdata, wstrb} <= {a, d, 4'hF};
        {awvalid, wvalid, bready} <= 3'h7;
        do begin
            @(posedge aclk);
            k++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid && k < 50);
        bready <= 1'b0;
        if (k >= 50) close_out(1'b1);
    endtask : wr
    task automatic rc(input logic [3:0] a, input logic [31:0] e);
        int k;
        k = 0;
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        do begin
            @(posedge aclk);
            k++;
            if (arready) arvalid <= 1'b0;
        end while (!rvalid && k < 50);
        rready <= 1'b0;
        check("rdata", rdata, e);
        if (k >= 50) close_out(1'b1);
    endtask : rc
    task automatic wt(input bit r, input int lim);
        n = 0;
        do begin
            @(posedge aclk);
            n++;
        end while (!(r ? device_reset : resume_inline) && n < lim);
    endtask : wt

    initial begin
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
        {awaddr, araddr, wdata, wstrb} = 44'h0;
        {ost_running, brownout_reset, power_on_reset, lfc} = 6'h0;
        master_clear_input_n = 1'b1;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        rc(4'h4, 32'h16);
        rc(4'h8, 32'h1B);
        core.irq(1'b1, 1'b0);
        core.op(0);
        @(posedge aclk);
        check("noop", {sleeping, prefetch_next}, 2'h1);
        rc(4'h0, 32'h18);
        core.irq(1'b0, 1'b0);
        for (int g = 0; g < 2; g++) begin
            core.op(0);
            @(posedge aclk);
            check("sleep", {sleeping, io_hold, prefetch_next}, 3'h7);
            check("clock", core_clk_en, 1'b0);
            rc(4'h0, 32'h10);
            core.irq(1'b1, g[0]);
            wt(1'b0, 40);
            check("wake", n, 3);
            check("isr", isr_call, g[0]);
            core.irq(1'b0, 1'b0);
        end
        for (int i = 0; i < 3; i++) begin
            wr(4'h4, ctl[i]);
            core.op(1);
            wt(1'b1, 600);
            check("expiry", n / 48, tq[i]);
            rc(4'h0, 32'h08);
            rc(4'h4, 32'h16);
        end
        wr(4'h4, 32'h0);
        repeat (4) begin
            core.op(1);
            wt(1'b1, 150);
            check("cleared", n, 150);
        end
        core.op(2);
        wt(1'b1, 200);
        check("oscfail", n, 200);
        ost_running <= 1'b1;
        wt(1'b1, 200);
        check("ost", n, 200);
        ost_running <= 1'b0;
        core.op(0);
        wt(1'b0, 400);
        check("wdt wake", n / 48, 5);
        rc(4'h0, 32'h00);
        wr(4'h8, 32'h1A);
        core.op(0);
        wt(1'b0, 400);
        check("mode10", n, 400);
        core.irq(1'b1, 1'b0);
        wt(1'b0, 40);
        core.irq(1'b0, 1'b0);
        wt(1'b1, 400);
        check("mode10 awake", n / 48, 5);
        wr(4'h8, 32'h18);
        wr(4'h4, 32'h1);
        wt(1'b1, 400);
        check("mode00", n, 400);
        wr(4'h8, 32'h19);
        core.op(1);
        wt(1'b1, 400);
        check("mode01", n / 48, 5);
        for (int r = 0; r < 3; r++) begin
            {master_clear_input_n, brownout_reset, power_on_reset} <=
                3'h4 ^ (3'h1 << r);
            wt(1'b1, 9);
            check("rst", n, r[1] ? 6 : 2);
            {master_clear_input_n, brownout_reset, power_on_reset} <= 3'h4;
            wt(1'b0, 9);
        end
        wr(4'h8, 32'h1C);
        core.op(0);
        core.irq(1'b1, 1'b0);
        wt(1'b0, 40);
        check("crystal", n / 5, 2);
        core.irq(1'b0, 1'b0);
        close_out(1'b0);
    end
endmodule : tb_sleep_and_watchdog_control
